// ---- dv/sfpfe_chk.sv ----
// Assertions on the pins of the flash front end top.
// Assumes link pins reach its logic through a few sync stages.
`timescale 1ns/1ps
// ====================
// Checker
module sfpfe_chk (
   // System
   input wire mclk,
   input wire resetn,
   // Register bus
   input wire wbCyc,
   input wire wbStb,
   input wire wbAck,
   // Link
   input wire sclk,
   input wire selectN,
   input wire [3:0] laneIn,
   input wire [3:0] laneOut,
   input wire [3:0] laneOeN,
   // Array side
   input wire abortPulse,
   input wire statusWriteBlock
);
   // Pin history long enough to cover sync and edge-detect lag
   logic [11:0] selH = 12'hFFF, sckH = 12'h000;
   logic [11:0] wpH = 12'hFFF, abH = 12'hFFF;
   wire fellSeen = |(sckH[11:1] & ~sckH[10:0]);
   always @(posedge mclk) begin
      selH <= {selH[10:0], selectN};
      sckH <= {sckH[10:0], sclk};
      wpH <= {wpH[10:0], laneIn[2]};
      abH <= {abH[10:0], laneIn[3]};
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (!resetn);
   deselOff_a: assert property (&selH |-> laneOeN == 4'hF)
      else $error("Lane driven while deselected");
   selDrive_a: assert property (laneOeN != 4'hF |-> !(&selH))
      else $error("Lane driven without select");
   outFall_a: assert property ($changed(laneOut) |-> fellSeen)
      else $error("Lane output moved without a falling edge");
   wpBlock_a: assert property (statusWriteBlock |-> !(&wpH))
      else $error("Write block without protect pin low");
   abortHold_a: assert property (abortPulse |-> abH == 12'h000
      && !$past(laneIn[3], 24)) else $error("Abort on a short low");
   abortOne_a: assert property (abortPulse |=> !abortPulse)
      else $error("Abort pulse longer than one cycle");
   ackNext_a: assert property (wbCyc && wbStb && !wbAck |=> wbAck)
      else $error("Bus answer late");
   ackDrop_a: assert property (wbAck |=> !wbAck)
      else $error("Bus answer held");
   cover property (abortPulse);
   cover property (statusWriteBlock);
   cover property (laneOeN == 4'h0);
endmodule
bind sfpfe_top sfpfe_chk u_chk (.mclk(mclk), .resetn(resetn),
   .wbCyc(wbCyc), .wbStb(wbStb), .wbAck(wbAck), .sclk(sclk),
   .selectN(selectN), .laneIn(laneIn), .laneOut(laneOut),
   .laneOeN(laneOeN), .abortPulse(abortPulse),
   .statusWriteBlock(statusWriteBlock));

// ---- dv/sfpfe_host.sv ----
// Host controller model for the flash front end link.
// Assumes mclk at 25 MHz; sclk is left low after a read, high after a bits burst.
`timescale 1ns/1ps
// ====================
// Host model
module sfpfe_host (
   // Pacing clock
   input wire mclk,
   // Link pins; hd marks lanes the host drives
   output logic sclk = 1'b0,
   output logic selectN = 1'b0,
   output logic [3:0] hv = 4'hF,
   output logic [3:0] hd = 4'hD,
   input wire [3:0] lanes,
   // Byte read back
   output logic rxValid = 1'b0,
   output logic [7:0] rxByte = 8'h00
);
   logic holdN = 1'b1;
   logic wpN = 1'b1;
   // Half of a 320 ns serial period, far under the top rate
   task automatic half;
      repeat (4) @(posedge mclk);
   endtask
   // Select moves at whatever level the clock was left, then half a period passes
   task automatic sel(input logic v);
      selectN <= v;
      half();
   endtask
   // Levels on the pause and protect pins
   task automatic park(input logic h3, input logic w2);
      holdN = h3;
      wpN = w2;
      hv[3:2] <= {h3, w2};
      hd[3:2] <= 2'b11;
   endtask
   // Pause mid-frame, clock junk while held, release with clock high
   task automatic pause;
      park(1'b0, wpN);
      bits(32'h5A000000, 4, 1);
      park(1'b1, wpN);
      half();
   endtask
   // n bits MSB first, w lanes a clock; data moves on the fall
   task automatic bits(input logic [31:0] v, input int n, input int w);
      logic [31:0] sh;
      sh = v;
      for (int i = 0; i < n; i += w) begin
         hv <= (w == 4) ? sh[31:28] : {holdN, wpN, 1'b1, sh[31]};
         hd <= (w == 4) ? 4'hF : 4'hD;
         sclk <= 1'b0;
         half();
         sclk <= 1'b1;
         half();
         sh = sh << w;
      end
   endtask
   // Read a byte, sampled late in the high phase so output lag is met
   task automatic rd(input int w);
      logic [7:0] sh;
      sh = 8'h00;
      hd <= (w == 4) ? 4'h0 : 4'hD;
      for (int i = 0; i < 8; i += w) begin
         sclk <= 1'b0;
         half();
         sclk <= 1'b1;
         repeat (3) @(posedge mclk);
         @(negedge mclk);
         sh = (w == 4) ? {sh[3:0], lanes} : {sh[6:0], lanes[1]};
         @(posedge mclk);
      end
      sclk <= 1'b0;
      rxByte <= sh;
      rxValid <= 1'b1;
      @(posedge mclk);
      rxValid <= 1'b0;
   endtask
endmodule

// ---- dv/sfpfe_top_tb.sv ----
// Self-checking bench for the flash pin front end.
// Assumes sfpfe_host plays the controller and sfpfe_chk is bound in.
`timescale 1ns/1ps
// ====================
// Bench
module sfpfe_top_tb;
   logic mclk = 1'b0, resetn = 1'b0, wbCyc = 1'b0, wbStb = 1'b0;
   logic wbWe = 1'b0, tog = 1'b0;
   logic [3:0] wbAdr = 4'h0, wbSel = 4'h0;
   logic [31:0] wbDatI = 32'h0;
   wire [31:0] wbDatO;
   wire [7:0] rxByte;
   wire wbAck, sclk, selectN, abortPulse, statusWriteBlock, rxValid;
   wire [3:0] laneIn, laneOut, laneOeN, hv, hd;
   logic [31:0] wbQ[$], lnQ[$];
   int n_fail = 0, checks = 0, nAbort = 0, seed = 17460;
   always #20 mclk = ~mclk;
   // Released lanes wander each cycle instead of keeping a value
   always @(posedge mclk) tog <= ~tog;
   assign laneIn = (~laneOeN & laneOut) | (laneOeN & hd & hv)
      | (laneOeN & ~hd & {4{tog}});
   sfpfe_top dut (.mclk(mclk), .resetn(resetn), .wbCyc(wbCyc),
      .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel),
      .wbDatI(wbDatI), .wbDatO(wbDatO), .wbAck(wbAck), .sclk(sclk),
      .selectN(selectN), .laneIn(laneIn), .laneOut(laneOut),
      .laneOeN(laneOeN), .arrayBusyDone(1'b0),
      .abortPulse(abortPulse), .statusWriteBlock(statusWriteBlock));
   sfpfe_host host (.mclk(mclk), .sclk(sclk), .selectN(selectN),
      .hv(hv), .hd(hd), .lanes(laneIn), .rxValid(rxValid),
      .rxByte(rxByte));
   task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
      checks++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic give_verdict;
      if (n_fail == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Classic cycle: hold until ack is sampled, then drop for a cycle
   task automatic wb(logic we, logic [3:0] a, logic [31:0] d);
      int t;
      t = 0;
      {wbCyc, wbStb, wbWe, wbAdr, wbSel, wbDatI} <= {2'b11, we, a, 4'hF, d};
      do begin
         @(posedge mclk);
         t++;
      end while (wbAck !== 1'b1 && t < 100);
      if (t >= 100)
         n_fail++;
      {wbCyc, wbStb} <= 2'b00;
      @(posedge mclk);
   endtask
   task automatic rdReg(logic [3:0] a, logic [31:0] e);
      wbQ.push_back(e);
      wb(1'b0, a, 32'h0);
   endtask
   // One read frame: instruction when wi > 0, address, one byte back
   task automatic frame(logic [7:0] i, logic [23:0] a, int wi, int wa,
         logic [7:0] tx, bit pz);
      wb(1'b1, 4'hC, {24'h0, tx});
      host.sel(1'b0);
      if (wi > 0)
         host.bits({i, 24'h0}, 8, wi);
      host.bits({a, 8'h0}, 12, wa);
      if (pz)
         host.pause();
      host.bits({a[11:0], 20'h0}, 12, wa);
      lnQ.push_back({24'h0, tx});
      host.rd(wa);
      host.sel(1'b1);
   endtask
   // Each result is matched against the oldest note of its kind
   always @(posedge mclk) begin
      if (wbAck === 1'b1 && wbWe === 1'b0)
         cmp("wbDatO", wbQ.pop_front(), wbDatO);
      if (rxValid === 1'b1)
         cmp("rxByte", lnQ.pop_front(), {24'h0, rxByte});
      if (abortPulse === 1'b1)
         nAbort++;
   end
   initial begin
      logic [7:0] i;
      logic [23:0] a;
      logic [7:0] cv [5];
      int n0;
      cv = '{8'h00, 8'h02, 8'h03, 8'h08, 8'h09};
      repeat (10) @(posedge mclk);
      resetn <= 1'b1;
      repeat (4) @(posedge mclk);
      rdReg(4'h0, 32'h0);
      rdReg(4'h2, 32'h0);
      // Select low since reset: these bits must be ignored
      host.bits($random(seed), 32, 1);
      host.sel(1'b1);
      rdReg(4'h8, 32'h0);
      for (int k = 0; k < 3; k++) begin
         i = $random(seed);
         a = $random(seed);
         frame(i, a, 1, 1, $random(seed), k[0]);
         rdReg(4'h8, {i, a});
      end
      wb(1'b1, 4'h0, 32'h05);
      frame(i, a, 4, 4, $random(seed), 1'b0);
      rdReg(4'h8, {i, a});
      wb(1'b1, 4'h0, 32'h15);
      a = $random(seed);
      frame(8'h00, a, 0, 4, $random(seed), 1'b0);
      rdReg(4'h8, {i, a});
      // Pause/abort pin and protect pin under each configuration
      foreach (cv[k]) begin
         wb(1'b1, 4'h0, {24'h0, cv[k]});
         n0 = nAbort;
         host.park(1'b0, 1'b0);
         repeat (40) @(posedge mclk);
         cmp("wpBlock", cv[k][3] & ~cv[k][0], statusWriteBlock);
         host.park(1'b1, 1'b1);
         repeat (8) @(posedge mclk);
         cmp("abortCount", cv[k] == 8'h02, nAbort - n0);
      end
      give_verdict();
   end
   // A hang ends the run through the same closing task
   initial begin
      repeat (40000) @(posedge mclk);
      n_fail++;
      give_verdict();
   end
endmodule

// ---- hdl/sfpfe_defs.vh ----
// Constants for the serial flash pin front end.
// Assumes a 25 MHz system clock sampling all link pins.
`ifndef SFPFE_DEFS_VH
`define SFPFE_DEFS_VH
// ======================================================
// Timing
`define SFPFE_CLK_NS 40
`define SFPFE_ABORT_NS 1000
`define SFPFE_ABORT_CYC ((`SFPFE_ABORT_NS + `SFPFE_CLK_NS - 1) / `SFPFE_CLK_NS)
// ======================================================
// Register map (word addresses are byte offsets)
`define SFPFE_ADR_CTRL 4'h0
`define SFPFE_ADR_STAT 4'h4
`define SFPFE_ADR_CMD 4'h8
`define SFPFE_ADR_RDAT 4'hC
// Control fields
`define SFPFE_B_QE 0
`define SFPFE_B_PINFN 1
`define SFPFE_B_QPI 2
`define SFPFE_B_LOCK 3
`define SFPFE_B_CONT 4
`define SFPFE_F_WRAP 6:5
`define SFPFE_B_BUSYSET 7
`define SFPFE_CTRL_RST 8'h00
// Wrap lengths in bytes, selected by a 2-bit code
`define SFPFE_WRAP8 7'h08
`define SFPFE_WRAP16 7'h10
`define SFPFE_WRAP32 7'h20
`define SFPFE_WRAP64 7'h40
// Instruction length and continuous read overhead
`define SFPFE_INST_BITS 4'h8
`define SFPFE_ADDR_BITS 5'h18
`define SFPFE_ONE 1'b1
`endif

// ---- hdl/sfpfe_top.v ----
// Pin front end of a serial NOR flash: select, lane use, pause, abort,
// write protect, and a Wishbone window onto the captured command state.
// Assumes all link pins are asynchronous to mclk and the serial clock
// stays well below mclk/4 so that its edges are seen by sampling.
// Summary of operation
// R1 - Serial input bits are sampled on serial clock rising edges.
// R2 - Outbound data changes only on serial clock falling edges.
// R3 - Dual and quad: lanes 0 and 1 are bidirectional, rise in, fall out.
// R4 - Standard and dual use lanes 0-1; quad and four-wire use lanes 0-3.
// R5 - Select high deselects and floats every data output.
// R6 - Instructions accepted and data driven only while select is low.
// R7 - An instruction needs a prior select falling edge since power-up.
// R8 - Internal erase or program cycles finish after deselect.
// R9 - Function select 0 with quad off makes pin 3 a low pause input.
// R10 - Pause while selected floats outputs, ignores clock and input.
// R11 - Pause release resumes the operation where it stopped.
// R12 - Function select 1 with quad off makes pin 3 a low abort input.
// R13 - Abort held low about one microsecond ends any operation.
// R14 - Quad enable makes pin 3 only data lane 3.
// R15 - Quad enable makes the protect pin only data lane 2.
// R16 - Quad off: protect pin low blocks status writes with the lock bit.
// R17 - Host keeps the serial clock at or below 104 MHz.
// R18 - Four-wire command mode takes the 8-bit instruction in 2 clocks.
// R19 - Continuous read takes a 24-bit address with no instruction byte.
// R20 - Wrapped reads wrap at 8, 16, 32 or 64 bytes.
// R21 - Bytes travel MSB first; either clock idle level, rising sample.
`timescale 1ns/1ps
`include "sfpfe_defs.vh"
module sfpfe_top (
   // System
   input wire mclk,
   input wire resetn,
   // Wishbone slave
   input wire wbCyc,
   input wire wbStb,
   input wire wbWe,
   input wire [3:0] wbAdr,
   input wire [3:0] wbSel,
   input wire [31:0] wbDatI,
   output reg [31:0] wbDatO,
   output wire wbAck,
   // Serial link
   input wire sclk,
   input wire selectN,
   input wire [3:0] laneIn,
   output reg [3:0] laneOut,
   output reg [3:0] laneOeN,
   // Internal array side
   input wire arrayBusyDone,
   output wire abortPulse,
   output wire statusWriteBlock
);

   // ======================================================
   // Pin synchronisers: three stages, change counts when 2nd and 3rd agree
   reg [5:0] s1, s2, s3;
   reg [5:0] pinQ;
   wire [5:0] pinRaw = {sclk, selectN, laneIn};
   // Reset levels: clock low, select taken as low, lanes high. A select
   // held low through reset must never look like a falling edge.
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         s1 <= 6'h0F;
         s2 <= 6'h0F;
         s3 <= 6'h0F;
         pinQ <= 6'h0F;
      end else begin
         s1 <= pinRaw;
         s2 <= s1;
         s3 <= s2;
         pinQ <= (s2 & s3) | (pinQ & (s2 | s3));
      end
   end
   wire sclkS = pinQ[5];
   wire selN = pinQ[4];
   wire [3:0] lane = pinQ[3:0];

   // ======================================================
   // Control register and pin-3 function decode
   reg [7:0] ctrl_q;
   wire qe = ctrl_q[`SFPFE_B_QE];
   wire pinFn = ctrl_q[`SFPFE_B_PINFN];
   wire four_wire_command_mode = ctrl_q[`SFPFE_B_QPI];
   wire pauseActive = !qe && !pinFn && !lane[3] && !selN; // [R9] [R10]
   wire abortPin = !qe && pinFn && !lane[3];              // [R12] [R14]
   // Protect pin acts only while quad is off
   assign statusWriteBlock = !qe && !lane[2] &&
                             ctrl_q[`SFPFE_B_LOCK];      // [R16] [R15]

   // ======================================================
   // Edge detection on the sampled serial clock
   reg sclkPrev_q;
   reg armed_q;     // select has fallen since reset or the last abort
   reg selPrev_q;
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         sclkPrev_q <= 1'b0;
         selPrev_q <= 1'b0;
      end else begin
         sclkPrev_q <= sclkS;
         selPrev_q <= selN;
      end
   end
   // Frozen while paused so the command state is kept intact
   wire rise = sclkS && !sclkPrev_q && !selN && !pauseActive; // [R1] [R10]
   wire fall = !sclkS && sclkPrev_q && !selN && !pauseActive; // [R2] [R11]
   wire selFall = selPrev_q && !selN;

   // ======================================================
   // Abort timer: pin must stay low for the full minimum time
   reg [5:0] abortCnt_q;
   always @(posedge mclk or negedge resetn) begin
      if (!resetn)
         abortCnt_q <= 6'h00;
      else if (!abortPin)
         abortCnt_q <= 6'h00;
      else if (abortCnt_q != 6'h3F)
         abortCnt_q <= abortCnt_q + 6'h01;
   end
   assign abortPulse = (abortCnt_q == `SFPFE_ABORT_CYC - 1); // [R13]

   // ======================================================
   // Inbound shifter: instruction then address, MSB first
   localparam ST_IDLE = 2'h0;
   localparam ST_INST = 2'h1;
   localparam ST_ADDR = 2'h2;
   localparam ST_DATA = 2'h3;
   reg [1:0] state_q;
   reg [7:0] inst_q;
   reg [23:0] addr_q;
   reg [5:0] bitCnt_q;
   reg [1:0] width_q; // 0 single, 1 dual, 2 quad lanes per edge
   reg [7:0] txByte_q;
   reg [6:0] byteCnt_q;
   reg cmdSeen_q;
   reg [31:0] cmdCount_q;
   wire quadOk = qe || four_wire_command_mode;
   // Lanes in use per edge: quad lanes only with quad or four-wire mode
   wire [1:0] wIn = (state_q == ST_INST) ? (four_wire_command_mode ? 2'h2 : 2'h0) :
                    (width_q == 2'h2 && !quadOk) ? 2'h1 : width_q; // [R4]
   reg [5:0] step;
   always @* begin
      case (wIn)
         2'h0: step = 6'h01;
         2'h1: step = 6'h02;
         default: step = 6'h04;
      endcase
   end
   wire [6:0] wrapLen = (ctrl_q[6:5] == 2'h0) ? `SFPFE_WRAP8 :
                        (ctrl_q[6:5] == 2'h1) ? `SFPFE_WRAP16 :
                        (ctrl_q[6:5] == 2'h2) ? `SFPFE_WRAP32 :
                        `SFPFE_WRAP64;                     // [R20]

   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_q <= ST_IDLE;
         armed_q <= 1'b0;
         inst_q <= 8'h00;
         addr_q <= 24'h000000;
         bitCnt_q <= 6'h00;
         width_q <= 2'h0;
         byteCnt_q <= 7'h00;
         cmdSeen_q <= 1'b0;
         cmdCount_q <= 32'h00000000;
      end else if (abortPulse) begin
         state_q <= ST_IDLE;                               // [R13]
         armed_q <= 1'b0;
      end else if (selN) begin
         state_q <= ST_IDLE;                               // [R5]
      end else if (selFall) begin
         armed_q <= 1'b1;                                  // [R7]
         bitCnt_q <= 6'h00;
         // Address and data width follow quad enable only
         width_q <= qe ? 2'h2 : 2'h0;                      // [R4]
         byteCnt_q <= 7'h00;
         // Continuous read skips the instruction byte
         state_q <= (ctrl_q[`SFPFE_B_CONT] && cmdSeen_q) ?
                    ST_ADDR : ST_INST;                     // [R19]
      end else if (rise && armed_q) begin                  // [R6] [R7]
         case (state_q)
            ST_INST: begin
               // Four-wire mode: two nibbles make the instruction
               if (four_wire_command_mode)
                  inst_q <= {inst_q[3:0], lane};           // [R18] [R21]
               else
                  inst_q <= {inst_q[6:0], lane[0]};        // [R21]
               if (bitCnt_q + step == {2'h0, `SFPFE_INST_BITS}) begin
                  bitCnt_q <= 6'h00;
                  state_q <= ST_ADDR;
                  cmdSeen_q <= 1'b1;
                  cmdCount_q <= cmdCount_q + 32'h1;
               end else
                  bitCnt_q <= bitCnt_q + step;
            end
            ST_ADDR: begin
               case (wIn)
                  2'h0: addr_q <= {addr_q[22:0], lane[0]};
                  2'h1: addr_q <= {addr_q[21:0], lane[1:0]}; // [R3]
                  default: addr_q <= {addr_q[19:0], lane};   // [R4]
               endcase
               if (bitCnt_q + step == {1'b0, `SFPFE_ADDR_BITS}) begin
                  bitCnt_q <= 6'h00;
                  state_q <= ST_DATA;
               end else
                  bitCnt_q <= bitCnt_q + step;
            end
            ST_DATA: begin
               if (bitCnt_q + step == {2'h0, `SFPFE_INST_BITS}) begin
                  bitCnt_q <= 6'h00;
                  // Wrapped read returns to the start of its window
                  byteCnt_q <= (byteCnt_q + 7'h01 == wrapLen) ?
                               7'h00 : byteCnt_q + 7'h01;  // [R20]
               end else
                  bitCnt_q <= bitCnt_q + step;
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   // ======================================================
   // Outbound driver: changes only on falling edges, MSB first
   reg [7:0] shOut_q;
   reg driving_q;
   // A new byte starts from the transmit register, not the stale shifter
   wire [7:0] outSrc = (bitCnt_q == 6'h00) ? txByte_q : shOut_q;
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         shOut_q <= 8'h00;
         laneOut <= 4'h0;
         driving_q <= 1'b0;
      end else if (selN || abortPulse) begin
         driving_q <= 1'b0;
      end else if (fall && state_q == ST_DATA) begin      // [R2] [R3]
         driving_q <= 1'b1;
         case (wIn)
            2'h0: begin
               laneOut <= {2'h0, outSrc[7], 1'b0};         // Lane 1 out
               shOut_q <= {outSrc[6:0], 1'b0};
            end
            2'h1: begin
               laneOut <= {2'h0, outSrc[7:6]};
               shOut_q <= {outSrc[5:0], 2'h0};
            end
            default: begin
               laneOut <= outSrc[7:4];                     // [R15] [R14]
               shOut_q <= {outSrc[3:0], 4'h0};
            end
         endcase
      end
   end
   // Enables low while driving; pause and deselect float everything
   always @* begin
      laneOeN = 4'hF;
      if (driving_q && !selN && !pauseActive) begin       // [R5] [R10]
         case (wIn)
            2'h0: laneOeN = 4'hD;
            2'h1: laneOeN = 4'hC;                          // [R4]
            default: laneOeN = 4'h0;
         endcase
      end
   end

   // ======================================================
   // Internal busy: survives deselect, only abort or completion ends it
   reg busy_q;
   always @(posedge mclk or negedge resetn) begin
      if (!resetn)
         busy_q <= 1'b0;
      else if (abortPulse || arrayBusyDone)
         busy_q <= 1'b0;                                   // [R13]
      else if (wbAck && wbWe && wbAdr == `SFPFE_ADR_CTRL &&
               wbDatI[`SFPFE_B_BUSYSET])
         busy_q <= 1'b1;                                   // [R8]
   end

   // ======================================================
   // Wishbone slave: one wait state, ack drops the cycle after
   reg ack_q;
   assign wbAck = ack_q;
   always @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ack_q <= 1'b0;
         ctrl_q <= `SFPFE_CTRL_RST;
         txByte_q <= 8'h00;
         wbDatO <= 32'h00000000;
      end else begin
         ack_q <= wbCyc && wbStb && !ack_q;
         if (wbCyc && wbStb && !ack_q) begin
            case (wbAdr)
               `SFPFE_ADR_CTRL: wbDatO <= {24'h0, 1'b0, ctrl_q[6:0]};
               `SFPFE_ADR_STAT: wbDatO <= {20'h0, statusWriteBlock,
                  pauseActive, abortPin, busy_q, armed_q, selN,
                  state_q, 4'h0};
               `SFPFE_ADR_CMD: wbDatO <= {inst_q, addr_q};
               `SFPFE_ADR_RDAT: wbDatO <= {17'h0, byteCnt_q, txByte_q};
               default: wbDatO <= 32'h00000000;
            endcase
            if (wbWe && wbSel[0]) begin
               if (wbAdr == `SFPFE_ADR_CTRL)
                  ctrl_q <= {1'b0, wbDatI[6:0]};
               if (wbAdr == `SFPFE_ADR_RDAT)
                  txByte_q <= wbDatI[7:0];
            end
         end
      end
   end
endmodule
